// ==== design/mcr_pkg.sv ====
// Package: main control word layout, reset values, measurement types.
// Notes on behaviour
// - Wake-up enable 0 forces periodic wake-up off; 1 follows wake-up registers only while powered, off while powered down.
// - Front gain select 0 is maximum gain, 1 minimum; resets to 0.
// - Measure select 0 routes ADC to strength field, 1 to supply field.
// - Data valid when strength is at least threshold plus hysteresis.
// - Data inhibited when strength is below threshold minus hysteresis.
// - Between the two levels the previous decision is kept.
// - Three-bit power level, 000 minimum, 111 maximum; resets to 000.
// - Tx frequency select 0 uses code zero, 1 uses code one; resets to 0.
// - Crystal select 0 means 10.245 MHz, 1 means 20.945 MHz; resets 0.
// - Discriminator range 0 narrow, 1 standard; resets to 1.
// - Polarity 0 inverts data pin, 1 passes it direct; resets to 1.
// - Slicer reference 0 external filter pin, 1 internal DAC; resets 1.
// - ADC source 0 supply measurement, 1 discriminator DC level; resets 0.
// - Strength measuring stops during supply measurement; last result retained.
// - No supply measurement while powered down.
// - Power-down bit 0 leaves only serial interface active; 1 activates.
// - Direction bit 0 receive, 1 transmit; chooses frequency selection.
package mcr_pkg;
	localparam logic [31:0] CTRL_RESET = 32'h10000270;
	localparam logic [31:0] CTRL_WMASK = 32'hfffffbf2;
	localparam int POS_PDN = 31;
	localparam int POS_DIR = 30;
	localparam int POS_WAKEUP_ENABLE = 26;
	localparam int POS_GAIN = 25;
	localparam int POS_MSEL = 24;
	localparam int POS_THR = 18;
	localparam int POS_HYS = 15;
	localparam int POS_PWR = 12;
	localparam int POS_TX_FREQ_SELECT = 11;
	localparam int POS_RX_FREQ_SELECT = 8;
	localparam int POS_XTAL = 7;
	localparam int POS_BW = 6;
	localparam int POS_POL = 5;
	localparam int POS_SREF = 4;
	localparam int POS_ASRC = 1;
	localparam int FIFO_DEPTH = 32;
	localparam logic [1:0] RX_FREQ_SELECT_RESET = 2'h2;

	typedef struct packed {
		logic [5:0] strength;
		logic [5:0] supply;
	} mcr_meas_type;

	typedef struct packed {
		logic wakeup_enable;
		logic front_gain_select;
		logic [2:0] tx_power_level;
		logic [1:0] freq_code_sel;
		logic crystal_select;
		logic discriminator_range;
		logic slicer_reference_select;
		logic adc_source_select;
	} mcr_analog_type;

	typedef enum logic [1:0] {
		MCR_IDLE = 2'b00,
		MCR_STRENGTH = 2'b01,
		MCR_SUPPLY = 2'b11
	} mcr_adc_type;
endpackage

// ==== design/mcr_fifo.sv ====
// FIFO buffering received data samples toward the data pin.
`timescale 1ns/1ps
module mcr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	// Handshake terms; full and empty come from the fill count
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_ff[rd_ff];

	// Storage, written only on push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	// Pointers wrap; depth assumed a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + AW'(1);
			end
			if (pop) begin
				rd_ff <= rd_ff + AW'(1);
			end
			if (push && !pop) begin
				cnt_ff <= cnt_ff + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_ff <= cnt_ff - (AW+1)'(1);
			end
		end
	end
endmodule

// ==== design/mcr_top.sv ====
// Main control word, measurement steering, strength gate and data pin path.
`timescale 1ns/1ps
module mcr_top
	import mcr_pkg::*;
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic WR_STROBE,
	input wire logic [31:0] WR_DATA,
	output logic [31:0] CTRL_RDATA,
	input wire logic ADC_DONE,
	input wire logic [5:0] ADC_VALUE,
	output logic ADC_START,
	output logic ADC_SUPPLY,
	output logic [5:0] MEASURED_STRENGTH,
	output logic [5:0] MEASURED_SUPPLY,
	output logic DATA_VALID,
	input wire logic DEMOD_DATA,
	output logic DEMOD_READY,
	output logic RADIO_DATA_PIN,
	output logic RADIO_ACTIVE,
	output logic TX_MODE,
	output mcr_analog_type ANALOG_CTRL
);
	logic [31:0] ctrl_ff;
	mcr_adc_type adc_st_ff;
	mcr_adc_type nxt_adc_st;
	mcr_meas_type meas_ff;
	logic valid_ff;
	logic demod_s1_ff;
	logic demod_s2_ff;
	logic out_ff;
	logic fifo_valid;
	logic fifo_data;
	logic pin_ff;
	logic [6:0] high_lvl;
	logic [6:0] low_lvl;
	logic [6:0] strength_ext;
	logic powered;
	logic supply_mode;
	logic conv_busy_ff;

	// Control word register; masked bits 10, 3, 2 and 0 kept at zero
	// Reserved bits masked
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_ff <= CTRL_RESET;
		end else if (WR_STROBE) begin
			ctrl_ff <= WR_DATA & CTRL_WMASK;
		end
	end

	assign CTRL_RDATA = ctrl_ff;
	assign powered = ctrl_ff[POS_PDN];
	assign TX_MODE = ctrl_ff[POS_DIR];
	assign RADIO_ACTIVE = powered;
	assign supply_mode = ctrl_ff[POS_MSEL] && powered;
	assign ADC_SUPPLY = (adc_st_ff == MCR_SUPPLY);

	// Analog steering fields; only wake-up enable is held off while powered down
	always_comb begin
		ANALOG_CTRL.wakeup_enable = ctrl_ff[POS_WAKEUP_ENABLE] && powered;
		ANALOG_CTRL.front_gain_select = ctrl_ff[POS_GAIN];
		ANALOG_CTRL.tx_power_level = ctrl_ff[POS_PWR +: 3];
		if (ctrl_ff[POS_DIR]) begin
			ANALOG_CTRL.freq_code_sel = {1'b0, ctrl_ff[POS_TX_FREQ_SELECT]};
		end else begin
			ANALOG_CTRL.freq_code_sel = ctrl_ff[POS_RX_FREQ_SELECT +: 2];
		end
		ANALOG_CTRL.crystal_select = ctrl_ff[POS_XTAL];
		ANALOG_CTRL.discriminator_range = ctrl_ff[POS_BW];
		ANALOG_CTRL.slicer_reference_select = ctrl_ff[POS_SREF];
		ANALOG_CTRL.adc_source_select = ctrl_ff[POS_ASRC];
	end

	// Measurement sequencer chooses the source for the next conversion
	always_comb begin
		case (adc_st_ff)
			MCR_IDLE: nxt_adc_st = !powered ? MCR_IDLE :
				(supply_mode ? MCR_SUPPLY : MCR_STRENGTH);
			MCR_STRENGTH: nxt_adc_st = !powered ? MCR_IDLE :
				((ADC_DONE && supply_mode) ? MCR_SUPPLY : MCR_STRENGTH);
			MCR_SUPPLY: nxt_adc_st = !powered ? MCR_IDLE :
				((ADC_DONE && !supply_mode) ? MCR_STRENGTH : MCR_SUPPLY);
			default: nxt_adc_st = MCR_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			adc_st_ff <= MCR_IDLE;
		end else begin
			adc_st_ff <= nxt_adc_st;
		end
	end

	// One start pulse per conversion; busy until done
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			conv_busy_ff <= 1'b0;
		end else if (adc_st_ff == MCR_IDLE || ADC_DONE) begin
			conv_busy_ff <= 1'b0;
		end else begin
			conv_busy_ff <= 1'b1;
		end
	end
	assign ADC_START = (adc_st_ff != MCR_IDLE) && !conv_busy_ff;

	// Result storage by measured source
	// Result to its field
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			meas_ff <= '0;
		end else if (ADC_DONE && adc_st_ff == MCR_STRENGTH) begin
			meas_ff.strength <= ADC_VALUE;
		end else if (ADC_DONE && adc_st_ff == MCR_SUPPLY) begin
			meas_ff.supply <= ADC_VALUE;
		end
	end
	assign MEASURED_STRENGTH = meas_ff.strength;
	assign MEASURED_SUPPLY = meas_ff.supply;

	// Levels widened so the sum cannot wrap; bit 6 of the difference marks a level below zero
	assign strength_ext = {1'b0, ADC_VALUE};
	assign high_lvl = {1'b0, ctrl_ff[POS_THR +: 6]} + {4'h0, ctrl_ff[POS_HYS +: 3]};
	assign low_lvl = {1'b0, ctrl_ff[POS_THR +: 6]} - {4'h0, ctrl_ff[POS_HYS +: 3]};

	// Hysteresis decision on each finished strength sample
	// Per sample, reset inhibited
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			valid_ff <= 1'b0;
		end else if (ADC_DONE && adc_st_ff == MCR_STRENGTH) begin
			if (strength_ext >= high_lvl) begin
				valid_ff <= 1'b1;
			end else if (!low_lvl[6] && strength_ext < low_lvl) begin
				valid_ff <= 1'b0;
			end
		end
	end
	assign DATA_VALID = valid_ff;

	// Demodulated data crosses in through two flops
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			demod_s1_ff <= 1'b0;
			demod_s2_ff <= 1'b0;
		end else begin
			demod_s1_ff <= DEMOD_DATA;
			demod_s2_ff <= demod_s1_ff;
		end
	end

	// Buffer decouples sampling from pin drive
	mcr_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst_n(RSTN),
		.in_valid(powered),
		.in_ready(DEMOD_READY),
		.in_data(demod_s2_ff),
		.out_valid(fifo_valid),
		.out_ready(powered),
		.out_data(fifo_data)
	);

	// Pin drive: polarity applied, held low while inhibited
	// Polarity select
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			out_ff <= 1'b0;
			pin_ff <= 1'b0;
		end else begin
			if (fifo_valid && powered) begin
				out_ff <= ctrl_ff[POS_POL] ? fifo_data : !fifo_data;
			end
			pin_ff <= valid_ff && powered && out_ff;
		end
	end
	assign RADIO_DATA_PIN = pin_ff;
endmodule

// ==== tb/mcr_adc_model.sv ====
// Converter model: one result for each start, after a set latency.
`timescale 1ns/1ps
module mcr_adc_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [2:0] lat,
	input wire logic [5:0] val,
	output logic done,
	output logic [5:0] value
);
	logic busy_ff;
	logic [2:0] cnt_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			cnt_ff <= 3'h0;
			done <= 1'b0;
			value <= 6'h0;
		end else begin
			done <= busy_ff && cnt_ff == lat;
			// Stale result flips each cycle so a read one cycle late never matches
			value <= (busy_ff && cnt_ff == lat) ? val : ~value;
			cnt_ff <= start ? 3'h0 : cnt_ff + 3'h1;
			if (start)
				busy_ff <= 1'b1;
			else if (cnt_ff == lat)
				busy_ff <= 1'b0;
		end
	end
endmodule

// ==== tb/mcr_chk.sv ====
// Checker: control word, measurement steering and gate properties.
`timescale 1ns/1ps
module mcr_chk
	import mcr_pkg::*;
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic WR_STROBE,
	input wire logic [31:0] WR_DATA,
	input wire logic [31:0] CTRL_RDATA,
	input wire logic ADC_DONE,
	input wire logic [5:0] ADC_VALUE,
	input wire logic ADC_START,
	input wire logic ADC_SUPPLY,
	input wire logic [5:0] MEASURED_STRENGTH,
	input wire logic [5:0] MEASURED_SUPPLY,
	input wire logic DATA_VALID,
	input wire logic RADIO_DATA_PIN,
	input wire logic RADIO_ACTIVE,
	input wire logic TX_MODE,
	input wire mcr_analog_type ANALOG_CTRL
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	logic [5:0] thr;
	logic [2:0] hys;
	logic smp;
	logic act_ff;
	// Sequencer leaves idle one edge after power-up; a done while idle is ignored
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			act_ff <= 1'b0;
		end else begin
			act_ff <= RADIO_ACTIVE;
		end
	end
	// Widened sums keep threshold plus hysteresis from wrapping
	assign thr = CTRL_RDATA[23:18];
	assign hys = CTRL_RDATA[17:15];
	assign smp = ADC_DONE && act_ff && !ADC_SUPPLY;
	a_gate_opens: assert property (
		smp && 7'h0 + ADC_VALUE >= thr + hys |=> DATA_VALID) else $error("gate stayed shut");
	a_gate_shuts: assert property (
		smp && 7'h0 + ADC_VALUE + hys < thr |=> !DATA_VALID) else $error("gate stayed open");
	a_gate_holds: assert property (
		smp && 7'h0 + ADC_VALUE < thr + hys && 7'h0 + ADC_VALUE + hys >= thr
		|=> $stable(DATA_VALID)) else $error("gate changed in band");
	a_gate_idle: assert property (
		RADIO_ACTIVE && !smp |=> !RADIO_ACTIVE || $stable(DATA_VALID)) else $error("gate moved");
	a_strength_store: assert property (
		smp |=> MEASURED_STRENGTH == $past(ADC_VALUE)) else $error("strength not stored");
	a_supply_store: assert property (
		ADC_DONE && ADC_SUPPLY |=> MEASURED_SUPPLY == $past(ADC_VALUE)
		&& $stable(MEASURED_STRENGTH)) else $error("supply result wrong");
	a_no_start_off: assert property (
		!CTRL_RDATA[31] && !$past(CTRL_RDATA[31]) |-> !ADC_START) else $error("start unpowered");
	a_write_mask: assert property (
		WR_STROBE |=> CTRL_RDATA == ($past(WR_DATA) & CTRL_WMASK)) else $error("bad write");
	a_mode_bits: assert property (
		RADIO_ACTIVE == CTRL_RDATA[31] && TX_MODE == CTRL_RDATA[30]) else $error("mode wrong");
	a_freq_select: assert property (
		$stable(CTRL_RDATA) |=> $stable(CTRL_RDATA) |-> ANALOG_CTRL.freq_code_sel
		== (TX_MODE ? {1'b0, CTRL_RDATA[11]} : CTRL_RDATA[9:8])) else $error("freq sel");
	a_pin_off: assert property (
		!RADIO_ACTIVE [*3] |-> !RADIO_DATA_PIN) else $error("pin driven while off");
endmodule
bind mcr_top mcr_chk chk (
	.MCLK(MCLK),
	.RSTN(RSTN),
	.WR_STROBE(WR_STROBE),
	.WR_DATA(WR_DATA),
	.CTRL_RDATA(CTRL_RDATA),
	.ADC_DONE(ADC_DONE),
	.ADC_VALUE(ADC_VALUE),
	.ADC_START(ADC_START),
	.ADC_SUPPLY(ADC_SUPPLY),
	.MEASURED_STRENGTH(MEASURED_STRENGTH),
	.MEASURED_SUPPLY(MEASURED_SUPPLY),
	.DATA_VALID(DATA_VALID),
	.RADIO_DATA_PIN(RADIO_DATA_PIN),
	.RADIO_ACTIVE(RADIO_ACTIVE),
	.TX_MODE(TX_MODE),
	.ANALOG_CTRL(ANALOG_CTRL)
);

// ==== tb/tb.sv ====
// Testbench: control word, strength gate, supply and data pin checks.
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((e) !== (a)) begin fail_count++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module tb
	import mcr_pkg::*;
;
	logic MCLK = 1'b0;
	logic RSTN = 1'b0;
	logic WR_STROBE = 1'b0;
	logic DEMOD_DATA = 1'b0;
	logic [31:0] WR_DATA = 32'h0;
	logic [31:0] CTRL_RDATA;
	logic ADC_DONE, ADC_START, ADC_SUPPLY, DATA_VALID, DEMOD_READY;
	logic RADIO_DATA_PIN, RADIO_ACTIVE, TX_MODE;
	logic [5:0] ADC_VALUE, MEASURED_STRENGTH, MEASURED_SUPPLY;
	mcr_analog_type ANALOG_CTRL;
	logic [5:0] adc_val = 6'h0;
	logic [2:0] adc_lat = 3'h0;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	mcr_top uut (
		.MCLK(MCLK),
		.RSTN(RSTN),
		.WR_STROBE(WR_STROBE),
		.WR_DATA(WR_DATA),
		.CTRL_RDATA(CTRL_RDATA),
		.ADC_DONE(ADC_DONE),
		.ADC_VALUE(ADC_VALUE),
		.ADC_START(ADC_START),
		.ADC_SUPPLY(ADC_SUPPLY),
		.MEASURED_STRENGTH(MEASURED_STRENGTH),
		.MEASURED_SUPPLY(MEASURED_SUPPLY),
		.DATA_VALID(DATA_VALID),
		.DEMOD_DATA(DEMOD_DATA),
		.DEMOD_READY(DEMOD_READY),
		.RADIO_DATA_PIN(RADIO_DATA_PIN),
		.RADIO_ACTIVE(RADIO_ACTIVE),
		.TX_MODE(TX_MODE),
		.ANALOG_CTRL(ANALOG_CTRL)
	);
	mcr_adc_model adc (.clk(MCLK), .rst_n(RSTN), .start(ADC_START), .lat(adc_lat),
		.val(adc_val), .done(ADC_DONE), .value(ADC_VALUE));
	// 40 MHz clock
	always #12.5 MCLK = ~MCLK;
	// Hang guard, far above the few hundred cycles needed
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Strobe a word, then let control and steering settle
	task automatic wr(input logic [31:0] d);
		@(posedge MCLK);
		WR_STROBE <= 1'b1;
		WR_DATA <= d;
		@(posedge MCLK);
		WR_STROBE <= 1'b0;
		repeat (2) @(posedge MCLK);
		#1;
	endtask
	// Next conversion of the wanted kind returns v
	task automatic meas(input logic [5:0] v, input logic sup);
		adc_val = v;
		for (int i = 0; i < 40; i++) begin
			@(posedge MCLK);
			#1;
			if (ADC_DONE === 1'b1 && ADC_SUPPLY === sup)
				break;
		end
		@(posedge MCLK);
		#1;
	endtask
	task automatic t_fields();
		`CHK("ctrl", CTRL_RESET, CTRL_RDATA)
		`CHK("analog", 11'h026, ANALOG_CTRL)
		`CHK("valid", 1'b0, DATA_VALID)
		wr(32'h7fffffff);
		`CHK("ctrl", 32'h7ffffbf2, CTRL_RDATA)
		`CHK("analog", 11'h3df, ANALOG_CTRL)
		for (int i = 0; i < 4; i++) begin
			wr(32'h0 | (i << 8));
			`CHK("rx_freq_select", i[1:0], ANALOG_CTRL.freq_code_sel)
		end
		`CHK("active", 1'b0, RADIO_ACTIVE)
		$display("test fields done");
	endtask
	task automatic t_gate();
		logic [5:0] seq [10] = '{6'h1b, 6'h20, 6'h23, 6'h24, 6'h23, 6'h20, 6'h1d, 6'h1c,
			6'h1b, 6'h19};
		logic [9:0] ev = 10'h0f8;
		wr(32'h84820020);
		`CHK("wake", 1'b1, ANALOG_CTRL.wakeup_enable)
		for (int i = 0; i < 10; i++) begin
			adc_lat = (i < 5) ? 3'h0 : 3'h6;
			meas(seq[i], 1'b0);
			`CHK("strength", seq[i], MEASURED_STRENGTH)
			`CHK("valid", ev[i], DATA_VALID)
		end
		$display("test gate done");
	endtask
	task automatic t_pin();
		meas(6'h28, 1'b0);
		@(posedge MCLK);
		DEMOD_DATA <= 1'b1;
		repeat (12) @(posedge MCLK);
		#1;
		`CHK("pin", 1'b1, RADIO_DATA_PIN)
		`CHK("ready", 1'b1, DEMOD_READY)
		wr(32'h84820000);
		@(posedge MCLK);
		DEMOD_DATA <= 1'b0;
		repeat (12) @(posedge MCLK);
		#1;
		`CHK("pin", 1'b1, RADIO_DATA_PIN)
		@(posedge MCLK);
		DEMOD_DATA <= 1'b1;
		repeat (12) @(posedge MCLK);
		#1;
		`CHK("pin", 1'b0, RADIO_DATA_PIN)
		@(posedge MCLK);
		DEMOD_DATA <= 1'b0;
		#1;
		// Weak sample below the low level must shut the pin
		meas(6'h10, 1'b0);
		repeat (8) @(posedge MCLK);
		#1;
		`CHK("valid", 1'b0, DATA_VALID)
		`CHK("pin", 1'b0, RADIO_DATA_PIN)
		$display("test pin done");
	endtask
	task automatic t_supply();
		int n;
		n = 0;
		wr(32'hc5820020);
		// A strength sample still in flight completes and is stored before supply starts
		meas(6'h10, 1'b0);
		meas(6'h32, 1'b1);
		`CHK("supply", 6'h32, MEASURED_SUPPLY)
		`CHK("strength", 6'h10, MEASURED_STRENGTH)
		wr(32'h01000000);
		repeat (20) begin
			@(posedge MCLK);
			#1;
			if (ADC_START !== 1'b0)
				n++;
		end
		`CHK("starts", 0, n)
		$display("test supply done");
	endtask
	initial begin
		repeat (3) @(posedge MCLK);
		RSTN <= 1'b1;
		@(posedge MCLK);
		#1;
		t_fields();
		t_gate();
		t_pin();
		t_supply();
		final_report();
	end
endmodule
